// ===== pnpc_card_control.v
// Card-level Plug and Play control register set with index/data access
// Summary of operation
// - Read-port-setting write loads data bits 7-0 into read port address 9-2.
// - Read-port-setting reads are ignored; read port address bits 1-0 stay 11.
// - Each isolation read makes an isolating card compare one more ID bit.
// - Command register is write-only; its command bits clear themselves.
// - Reset bit resets logical devices and registers, keeps card number.
// - Return bit moves card to wait-for-key, keeps number and devices.
// - Number-clear bit sets the card number to zero.
// - Wake with matching number in sleep goes isolation if zero else config.
// - Any wake write restarts resource readout from the first byte.
// - Status bit 0 is one exactly when the next resource byte is ready.
// - Card number write assigns the number that wake commands match.
// - Logical unit number selects device for config and activate commands.
// - Single-device card returns 00h from the logical unit register.
// - Index reads back last written; data reads the indexed register.
// - Strap low at reset hides registers until protocol; high opens them.
`timescale 1ns/1ns
`default_nettype none
`include "pnpc_regs.vh"
module pnpc_card_control
(
  input wire i_clock,
  input wire i_reset_n,
  input wire i_base_address_strap,
  input wire i_key_done,
  input wire i_index_write,
  input wire i_data_write,
  input wire i_index_read,
  input wire i_data_read,
  input wire [7:0] i_wdata,
  input wire [7:0] i_res_data,
  input wire i_res_valid,
  output reg o_res_ready,
  input wire i_id_bit,
  input wire i_isol_drive,
  output reg [7:0] o_rdata,
  output reg o_rvalid,
  output reg [9:0] o_read_port_address,
  output reg [1:0] o_card_state,
  output reg [7:0] o_card_number,
  output reg [7:0] o_logical_unit,
  output reg o_unit_reset,
  output reg o_isol_compare,
  output reg o_resource_restart
);
  reg strap_s1;
  reg strap_s2;
  reg key_s1;
  reg key_s2;
  reg key_d;
  reg strap_caught;
  reg released;
  reg [7:0] index;
  reg [1:0] state;
  reg [1:0] next_state;
  wire key_rise;
  wire accessible;
  wire wr;
  wire rd;
  wire fifo_ready;
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire fifo_pop;
  wire fifo_push;
  reg flush;
  // ----------------------------------------
  // Index matching
  // ----------------------------------------
  function is_idx;
    input [7:0] a;
    input [7:0] b;
    begin
      is_idx = (a == b);
    end
  endfunction
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Strap stages run through reset so the level is settled at release
  always @(posedge i_clock)
  begin
    strap_s1 <= i_base_address_strap;
    strap_s2 <= strap_s1;
  end
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      key_s1 <= 1'b0;
      key_s2 <= 1'b0;
      key_d <= 1'b0;
    end
    else
    begin
      key_s1 <= i_key_done;
      key_s2 <= key_s1;
      key_d <= key_s2;
    end
  end
  assign key_rise = key_s2 && !key_d;
  // Strap captured on the first clock after reset release
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      released <= 1'b0;
      strap_caught <= 1'b0;
    end
    else if (!released)
    begin
      released <= 1'b1;
      strap_caught <= strap_s2;
    end
  end
  assign accessible = released && (strap_caught || state != `PNPC_ST_WAITKEY);
  assign wr = i_data_write && accessible;
  assign rd = i_data_read && accessible;
  // ----------------------------------------
  // Resource byte buffer
  // ----------------------------------------
  assign fifo_pop = rd && is_idx(index, `PNPC_IDX_RDATA)
    && state == `PNPC_ST_CONFIG;
  // Push only on the handshake the source sees
  assign fifo_push = i_res_valid && o_res_ready;
  pnpc_fifo #(.WIDTH(8), .DEPTH(4), .AW(2)) u_fifo
  (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_flush(flush),
    .i_data(i_res_data),
    .i_valid(fifo_push),
    .o_ready(fifo_ready),
    .o_data(fifo_data),
    .o_valid(fifo_valid),
    .i_ready(fifo_pop)
  );
  // ----------------------------------------
  // Card state machine
  // ----------------------------------------
  always @*
  begin
    next_state = state;
    case (state)
      `PNPC_ST_WAITKEY:
        if (key_rise)
          next_state = `PNPC_ST_SLEEP;
      `PNPC_ST_SLEEP:
        if (wr && is_idx(index, `PNPC_IDX_WAKE)
            && i_wdata == o_card_number)
        begin
          if (i_wdata == 8'h00)
            next_state = `PNPC_ST_ISOL;
          else
            next_state = `PNPC_ST_CONFIG;
        end
      `PNPC_ST_ISOL, `PNPC_ST_CONFIG:
        if (wr && is_idx(index, `PNPC_IDX_WAKE)
            && i_wdata != o_card_number)
          next_state = `PNPC_ST_SLEEP;
        else if (wr && is_idx(index, `PNPC_IDX_CARDNUM)
            && state == `PNPC_ST_ISOL)
          next_state = `PNPC_ST_CONFIG;
      default:
        next_state = `PNPC_ST_WAITKEY;
    endcase
    if (wr && is_idx(index, `PNPC_IDX_CMD)
        && i_wdata[`PNPC_CMD_WAITKEY] && state != `PNPC_ST_WAITKEY)
      next_state = `PNPC_ST_WAITKEY;
  end
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
      state <= `PNPC_ST_WAITKEY;
    else
      state <= next_state;
  end
  // ----------------------------------------
  // Register writes and side effects
  // ----------------------------------------
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      index <= `PNPC_IDX_RESET;
      o_read_port_address <= `PNPC_RDPORT_RESET;
      o_card_number <= `PNPC_CARDNUM_RESET;
      o_logical_unit <= `PNPC_LUNIT_RESET;
      o_unit_reset <= 1'b0;
      o_isol_compare <= 1'b0;
      o_resource_restart <= 1'b0;
      flush <= 1'b0;
      o_card_state <= `PNPC_ST_WAITKEY;
      o_res_ready <= 1'b0;
    end
    else
    begin
      o_unit_reset <= 1'b0;
      o_isol_compare <= 1'b0;
      o_resource_restart <= 1'b0;
      flush <= 1'b0;
      o_card_state <= next_state;
      // Registered ready drops after each push so no byte is lost
      o_res_ready <= fifo_ready && !flush && !fifo_push;
      if (i_index_write && accessible)
        index <= i_wdata;
      if (wr && is_idx(index, `PNPC_IDX_RDPORT)
          && state == `PNPC_ST_ISOL)
        o_read_port_address <= {i_wdata, `PNPC_RDPORT_LOW};
      if (wr && is_idx(index, `PNPC_IDX_CMD))
      begin
        if (i_wdata[`PNPC_CMD_RESET] && state != `PNPC_ST_WAITKEY)
        begin
          o_unit_reset <= 1'b1;
          o_read_port_address <= `PNPC_RDPORT_RESET;
          o_logical_unit <= `PNPC_LUNIT_RESET;
        end
        if (i_wdata[`PNPC_CMD_CLRNUM])
          o_card_number <= 8'h00;
      end
      if (wr && is_idx(index, `PNPC_IDX_WAKE))
      begin
        o_resource_restart <= 1'b1;
        flush <= 1'b1;
      end
      if (wr && is_idx(index, `PNPC_IDX_CARDNUM)
          && (state == `PNPC_ST_ISOL || state == `PNPC_ST_CONFIG))
        o_card_number <= i_wdata;
      if (wr && is_idx(index, `PNPC_IDX_LUNIT)
          && state == `PNPC_ST_CONFIG)
        o_logical_unit <= 8'h00;
      if (rd && is_idx(index, `PNPC_IDX_ISOL) && state == `PNPC_ST_ISOL)
        o_isol_compare <= 1'b1;
    end
  end
  // ----------------------------------------
  // Read data path
  // ----------------------------------------
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rvalid <= (i_index_read || i_data_read) && accessible;
      // Read data stands until the next taken read
      if ((i_index_read || i_data_read) && accessible)
      begin
        if (i_index_read)
          o_rdata <= index;
        else if (is_idx(index, `PNPC_IDX_ISOL))
          o_rdata <= (i_isol_drive && i_id_bit) ? 8'h55 : 8'hAA;
        else if (is_idx(index, `PNPC_IDX_RDATA))
          o_rdata <= fifo_valid ? fifo_data : 8'h00;
        else if (is_idx(index, `PNPC_IDX_STATUS))
          o_rdata <= {7'h00, fifo_valid && !flush};
        else if (is_idx(index, `PNPC_IDX_CARDNUM))
          o_rdata <= o_card_number;
        else if (is_idx(index, `PNPC_IDX_LUNIT))
          o_rdata <= o_logical_unit;
        else
          o_rdata <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// ===== pnpc_card_control_properties.sv
// Port checks for the card control register set
`timescale 1ns/1ns
`default_nettype none
`include "pnpc_regs.vh"
module pnpc_card_props
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_base_address_strap,
  input wire logic i_index_write,
  input wire logic i_data_write,
  input wire logic i_data_read,
  input wire logic [7:0] i_wdata,
  input wire logic [9:0] o_read_port_address,
  input wire logic [1:0] o_card_state,
  input wire logic [7:0] o_card_number,
  input wire logic o_isol_compare,
  input wire logic o_unit_reset,
  input wire logic o_resource_restart
);
  logic [7:0] ix;
  logic rel;
  logic sc;
  wire logic w = i_data_write && o_card_state != `PNPC_ST_WAITKEY;
  wire logic c = w && ix == `PNPC_IDX_CMD && !i_wdata[2];
  // Index copy follows only accesses the card takes
  always @(posedge i_clock)
    if (!i_reset_n)
    begin
      ix <= 8'h00;
      rel <= 1'b0;
    end
    else
    begin
      if (!rel)
        sc <= i_base_address_strap;
      rel <= 1'b1;
      if (i_index_write && rel
          && (sc || o_card_state != `PNPC_ST_WAITKEY))
        ix <= i_wdata;
    end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  property p_port;
    w && ix == `PNPC_IDX_RDPORT && o_card_state == `PNPC_ST_ISOL
      |=> o_read_port_address[9:2] == $past(i_wdata);
  endproperty
  a_port: assert property (p_port) else $error("port load");
  property p_low; o_read_port_address[1:0] == 2'h3; endproperty
  a_low: assert property (p_low) else $error("port low bits");
  property p_isol;
    i_data_read && ix == `PNPC_IDX_ISOL && o_card_state == `PNPC_ST_ISOL
      |=> o_isol_compare ##1 (o_isol_compare == $past(i_data_read
      && ix == `PNPC_IDX_ISOL && o_card_state == `PNPC_ST_ISOL));
  endproperty
  a_isol: assert property (p_isol) else $error("isol compare");
  property p_rst;
    c && i_wdata[0] |=> o_unit_reset && $stable(o_card_number)
      && o_read_port_address == 10'h203 ##1 (o_unit_reset ==
      $past(w && ix == `PNPC_IDX_CMD && i_wdata[0]));
  endproperty
  a_rst: assert property (p_rst) else $error("reset cmd");
  property p_ret;
    c && i_wdata[1] |=> o_card_state == 2'h0 && $stable(o_card_number);
  endproperty
  a_ret: assert property (p_ret) else $error("return cmd");
  property p_clr;
    w && ix == `PNPC_IDX_CMD && i_wdata[2] |=> o_card_number == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("number clear");
  property p_wake;
    w && ix == `PNPC_IDX_WAKE && o_card_state == `PNPC_ST_SLEEP
      && i_wdata == o_card_number |=> o_card_state ==
      ($past(i_wdata) == 8'h00 ? `PNPC_ST_ISOL : `PNPC_ST_CONFIG);
  endproperty
  a_wake: assert property (p_wake) else $error("wake state");
  property p_rs; w && ix == `PNPC_IDX_WAKE |=> o_resource_restart; endproperty
  a_rs: assert property (p_rs) else $error("restart");
  property p_num;
    w && ix == `PNPC_IDX_CARDNUM && o_card_state[1]
      |=> o_card_number == $past(i_wdata);
  endproperty
  a_num: assert property (p_num) else $error("number write");
  c_rs: cover property (o_resource_restart);
  c_isol: cover property (o_isol_compare);
  c_cfg: cover property (o_card_state == `PNPC_ST_CONFIG);
endmodule
bind pnpc_card_control pnpc_card_props pnpc_card_props_i (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_index_write(i_index_write),
  .i_base_address_strap(i_base_address_strap),
  .i_data_write(i_data_write), .i_data_read(i_data_read), .i_wdata(i_wdata),
  .o_read_port_address(o_read_port_address), .o_card_state(o_card_state),
  .o_card_number(o_card_number), .o_isol_compare(o_isol_compare),
  .o_unit_reset(o_unit_reset), .o_resource_restart(o_resource_restart));
`default_nettype wire

// ===== pnpc_fifo.v
// Small valid/ready FIFO for resource bytes
`timescale 1ns/1ns
`default_nettype none
module pnpc_fifo
#(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
)
(
  input wire i_clock,
  input wire i_reset_n,
  input wire i_flush,
  input wire [WIDTH-1:0] i_data,
  input wire i_valid,
  output wire o_ready,
  output wire [WIDTH-1:0] o_data,
  output wire o_valid,
  input wire i_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  assign o_ready = (count != DEPTH[AW:0]);
  assign o_valid = (count != {(AW+1){1'b0}});
  assign o_data = mem[rd_ptr];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  always @(posedge i_clock)
  begin
    if (push)
      mem[wr_ptr] <= i_data;
  end
  always @(posedge i_clock)
  begin
    if (!i_reset_n || i_flush)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== pnpc_regs.vh
// Register indices, fields and constants for the card control register set
`ifndef PNPC_REGS_VH
`define PNPC_REGS_VH
`define PNPC_IDX_RDPORT 8'h00
`define PNPC_IDX_ISOL 8'h01
`define PNPC_IDX_CMD 8'h02
`define PNPC_IDX_WAKE 8'h03
`define PNPC_IDX_RDATA 8'h04
`define PNPC_IDX_STATUS 8'h05
`define PNPC_IDX_CARDNUM 8'h06
`define PNPC_IDX_LUNIT 8'h07
`define PNPC_CMD_RESET 0
`define PNPC_CMD_WAITKEY 1
`define PNPC_CMD_CLRNUM 2
`define PNPC_STATUS_READY 0
`define PNPC_RDPORT_LOW 2'h3
`define PNPC_RDPORT_RESET 10'h203
`define PNPC_CARDNUM_RESET 8'h00
`define PNPC_LUNIT_RESET 8'h00
`define PNPC_IDX_RESET 8'h00
`define PNPC_ST_WAITKEY 2'h0
`define PNPC_ST_SLEEP 2'h1
`define PNPC_ST_ISOL 2'h2
`define PNPC_ST_CONFIG 2'h3
`endif

// ===== pnpc_res_src.sv
// Resource byte source standing behind the card's FIFO
`timescale 1ns/1ns
`default_nettype none
module pnpc_res_src
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_restart,
  input wire logic i_run,
  input wire logic i_slow,
  input wire logic i_ready,
  output logic [7:0] o_data,
  output logic o_valid
);
  logic [7:0] n;
  logic [7:0] last;
  logic ph;
  // Bytes count up from A0h; idle data shows the inverse of the last
  assign o_data = o_valid ? 8'hA0 + n : ~last;
  always @(posedge i_clock)
  begin
    ph <= i_reset_n & ~ph;
    if (!i_reset_n || i_restart)
    begin
      n <= 8'h00;
      last <= 8'h00;
      o_valid <= 1'b0;
    end
    else
    begin
      if (o_valid && i_ready)
      begin
        n <= n + 8'h01;
        last <= o_data;
      end
      if (!o_valid || i_ready)
        o_valid <= i_run & (ph | ~i_slow);
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Directed test of the card control register set
`timescale 1ns/1ns
`default_nettype none
`include "pnpc_regs.vh"
module tb_top;
  logic i_clock, i_reset_n, key, iw, dw, ir, dr, idb, drv, run, rv, rr, rp;
  logic rvalid, rvs, strap;
  logic [7:0] wd, res_d, rdata, num, v, lu;
  logic [9:0] port;
  logic [1:0] st;
  int miscompares, n_checks, k;
  pnpc_card_control pnpc_card_control_i (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .i_base_address_strap(strap), .i_key_done(key),
    .i_index_write(iw), .i_data_write(dw), .i_index_read(ir),
    .i_data_read(dr), .i_wdata(wd), .i_res_data(res_d), .i_res_valid(rv),
    .o_res_ready(rr), .i_id_bit(idb), .i_isol_drive(drv), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_read_port_address(port), .o_card_state(st),
    .o_card_number(num), .o_logical_unit(lu), .o_unit_reset(),
    .o_isol_compare(), .o_resource_restart(rp));
  pnpc_res_src pnpc_res_src_i (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_restart(rp), .i_run(run), .i_slow(1'b1), .i_ready(rr),
    .o_data(res_d), .o_valid(rv));
  initial
  begin
    i_clock = 0;
    forever #4 i_clock = ~i_clock;
  end
  task chk(input string n, input [9:0] s, input [9:0] e);
    n_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task wi(input [7:0] a);
    @(posedge i_clock);
    iw <= 1;
    wd <= a;
    @(posedge i_clock);
    iw <= 0;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    wi(a);
    dw <= 1;
    wd <= d;
    @(posedge i_clock);
    dw <= 0;
    #1;
  endtask
  task rd(input bit x, input [7:0] a, output [7:0] r);
    wi(a);
    ir <= x;
    dr <= !x;
    @(posedge i_clock);
    ir <= 0;
    dr <= 0;
    #1;
    r = rdata;
    rvs = rvalid;
  endtask
  task poll;
    v = 8'h00;
    for (int i = 0; i < 40 && v[0] !== 1'b1; i++)
      rd(0, `PNPC_IDX_STATUS, v);
    chk("ready", v[0], 1'b1);
  endtask
  initial
  begin
    repeat (20000) @(posedge i_clock);
    miscompares++;
    complete_run;
  end
  initial
  begin
    {i_reset_n, key, iw, dw, ir, dr, wd, idb, drv, run} = 0;
    strap = 1;
    repeat (4) @(posedge i_clock);
    i_reset_n <= 1;
    repeat (3) @(posedge i_clock);
    wr(`PNPC_IDX_LUNIT, 8'h33);
    rd(1, `PNPC_IDX_LUNIT, v);
    chk("index", v, 8'h07);
    chk("valid", rvs, 1'b1);
    rd(0, `PNPC_IDX_LUNIT, v);
    chk("lunit", v, 8'h00);
    chk("unit port", lu, 8'h00);
    key <= 1;
    idb <= 1;
    drv <= 1;
    for (k = 0; k < 20 && st !== `PNPC_ST_SLEEP; k++)
      @(posedge i_clock);
    wr(`PNPC_IDX_WAKE, 8'h00);
    chk("to isol", st, `PNPC_ST_ISOL);
    rd(0, `PNPC_IDX_ISOL, v);
    chk("id one", v, 8'h55);
    @(posedge i_clock);
    idb <= 0;
    rd(0, `PNPC_IDX_ISOL, v);
    chk("id zero", v, 8'hAA);
    wr(`PNPC_IDX_RDPORT, 8'h41);
    chk("port", port, 10'h107);
    wr(`PNPC_IDX_CARDNUM, 8'h05);
    rd(0, `PNPC_IDX_CARDNUM, v);
    chk("number", v, 8'h05);
    @(posedge i_clock);
    run <= 1;
    for (k = 0; k < 3; k++)
    begin
      poll;
      rd(0, `PNPC_IDX_RDATA, v);
      chk("byte", v, 8'hA0 + k);
    end
    repeat (20) @(posedge i_clock);
    run <= 0;
    wr(`PNPC_IDX_WAKE, 8'h09);
    chk("to sleep", st, `PNPC_ST_SLEEP);
    wr(`PNPC_IDX_WAKE, 8'h05);
    chk("to config", st, `PNPC_ST_CONFIG);
    @(posedge i_clock);
    run <= 1;
    poll;
    rd(0, `PNPC_IDX_RDATA, v);
    chk("first byte", v, 8'hA0);
    wr(`PNPC_IDX_CMD, 8'h01);
    chk("reset port", port, 10'h203);
    chk("kept number", num, 8'h05);
    wr(`PNPC_IDX_CMD, 8'h04);
    chk("cleared", num, 8'h00);
    wr(`PNPC_IDX_CMD, 8'h02);
    chk("wait key", st, `PNPC_ST_WAITKEY);
    key <= 0;
    strap <= 0;
    i_reset_n <= 0;
    repeat (4) @(posedge i_clock);
    i_reset_n <= 1;
    repeat (3) @(posedge i_clock);
    chk("reset port", port, 10'h203);
    chk("reset number", num, 8'h00);
    rd(1, `PNPC_IDX_CARDNUM, v);
    chk("hidden", rvs, 1'b0);
    key <= 1;
    for (k = 0; k < 20 && st !== `PNPC_ST_SLEEP; k++)
      @(posedge i_clock);
    rd(1, `PNPC_IDX_CARDNUM, v);
    chk("opened", v, 8'h06);
    complete_run;
  end
endmodule
`default_nettype wire
